/* verilog/fpc_top.sv */
// Front panel pushbuttons, reset sources, indicators and register port
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module fpc_top
    import fpc_pkg::*;
#(
    parameter int unsigned DEB_CYC = FPC_DEB_CYC
)
(
    // Clock and control
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Pushbuttons, high while pressed
    input  wire logic        abort_btn,
    input  wire logic        reset_btn,
    // Reset sources and role
    input  wire logic        powerup_rst,
    input  wire logic        wdog_expired,
    input  wire logic        sys_ctrl_role,
    // Board conditions
    input  wire logic        board_fault,
    input  wire logic        cpu_halted,
    input  wire logic        lbus_cycle_active,
    input  wire logic        net_owns_lbus,
    input  wire logic        disk_owns_lbus,
    input  wire logic        bp_master_xfer,
    input  wire logic        bp_slave_access,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Resets and interrupt
    output logic             onboard_rst,
    output logic             sysreset_out,
    output logic             sysreset_oe,
    output logic             irq,
    // Indicators
    output logic             fail_led,
    output logic             stat_led,
    output logic             run_led,
    output logic             sys_controller_led,
    output logic             network_activity_led,
    output logic             disk_activity_led,
    output logic             bp_activity_led
);
    logic        abort_pulse;
    logic        reset_level;
    logic        reset_pulse;
    logic [2:0]  status_ff;
    logic [2:0]  nxt_status;
    logic [2:0]  mask_ff;
    logic        sw_sysrst_ff;
    logic        wdog_d_ff;
    logic        onboard_rst_ff;
    logic        sysreset_ff;
    logic        sysreset_oe_ff;
    logic [31:0] rdata_ff;
    logic [6:0]  leds_ff;
    logic [2:0]  events;

    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction

    fpc_debounce #(.STABLE_CYC(DEB_CYC)) u_abort
    (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .raw_in      (abort_btn),
        .level_out   (),
        .press_pulse (abort_pulse)
    );

    fpc_debounce #(.STABLE_CYC(DEB_CYC)) u_reset
    (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .raw_in      (reset_btn),
        .level_out   (reset_level),
        .press_pulse (reset_pulse)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wdog_d_ff <= 1'b0;
        else if (ce)
            wdog_d_ff <= wdog_expired;
    end

    always_comb
    begin
        events = 3'h0;
        events[FPC_ST_ABORT] = abort_pulse;
        events[FPC_ST_RESET] = reset_pulse;
        events[FPC_ST_WDOG]  = wdog_expired && !wdog_d_ff;
    end

    // Set wins over a write-one clear landing in the same cycle
    always_comb
    begin
        nxt_status = status_ff;
        if (reg_wr && addr_hit(reg_addr, FPC_ADDR_STATUS))
            nxt_status = nxt_status & ~reg_wdata[2:0];
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status_ff <= FPC_STATUS_RST;
        else if (ce)
            status_ff <= nxt_status;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mask_ff      <= FPC_MASK_RST;
            sw_sysrst_ff <= 1'b0;
        end
        else if (ce && reg_wr)
        begin
            if (addr_hit(reg_addr, FPC_ADDR_MASK))
                mask_ff <= reg_wdata[2:0];
            if (addr_hit(reg_addr, FPC_ADDR_CTRL))
                sw_sysrst_ff <= reg_wdata[FPC_CTRL_SYSRST];
        end
    end

    assign irq = |(status_ff & mask_ff);

    // Reset outputs; the software bit is not self-clearing so software must drop it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            onboard_rst_ff <= 1'b1;
            sysreset_ff    <= 1'b0;
            sysreset_oe_ff <= 1'b0;
        end
        else if (ce)
        begin
            onboard_rst_ff <= reset_level || powerup_rst;
            sysreset_ff    <= 1'b0;
            sysreset_oe_ff <= sys_ctrl_role
                && (reset_level || powerup_rst
                    || wdog_expired || sw_sysrst_ff);
        end
    end

    assign onboard_rst  = onboard_rst_ff;
    assign sysreset_out = sysreset_ff;
    assign sysreset_oe  = sysreset_oe_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            leds_ff <= 7'h00;
        else if (ce)
        begin
            leds_ff[0] <= board_fault;
            leds_ff[1] <= cpu_halted;
            leds_ff[2] <= lbus_cycle_active;
            leds_ff[3] <= sys_ctrl_role;
            leds_ff[4] <= net_owns_lbus;
            leds_ff[5] <= disk_owns_lbus;
            leds_ff[6] <= bp_master_xfer || bp_slave_access;
        end
    end

    assign fail_led             = leds_ff[0];
    assign stat_led             = leds_ff[1];
    assign run_led              = leds_ff[2];
    assign sys_controller_led   = leds_ff[3];
    assign network_activity_led = leds_ff[4];
    assign disk_activity_led    = leds_ff[5];
    assign bp_activity_led      = leds_ff[6];

    // Unmapped addresses read zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_ff <= 32'h00000000;
        else if (ce)
        begin
            rdata_ff <= 32'h00000000;
            if (reg_rd)
            begin
                case (reg_addr)
                    FPC_ADDR_STATUS: rdata_ff <= {29'h0, status_ff};
                    FPC_ADDR_MASK:   rdata_ff <= {29'h0, mask_ff};
                    FPC_ADDR_CTRL:   rdata_ff <= {31'h0, sw_sysrst_ff};
                    FPC_ADDR_LEDS:   rdata_ff <= {25'h0, leds_ff};
                    default:         rdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_ff;

    // Status register: events stick, a write of ones clears
    AST_ABORT_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        ce && abort_pulse |=> status_ff[FPC_ST_ABORT])
        else $error("abort event lost");

    AST_RESET_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
        ce && reset_pulse |=> status_ff[FPC_ST_RESET])
        else $error("reset press event lost");

    AST_WDOG_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wdog_expired && !wdog_d_ff |=> status_ff[FPC_ST_WDOG])
        else $error("watchdog event lost");

    AST_W1C: assert property (@(posedge clk) disable iff (!rst_n)
        ce && reg_wr && reg_addr == FPC_ADDR_STATUS && events == 3'h0
        |=> (status_ff & $past(reg_wdata[2:0])) == 3'h0)
        else $error("status bit survived write-one clear");

    // Register port; rst_n in the antecedent keeps the reset edge out
    AST_MASK_WR: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && ce && reg_wr && reg_addr == FPC_ADDR_MASK
        |=> mask_ff == $past(reg_wdata[2:0]))
        else $error("mask write lost");

    AST_RD_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && ce && reg_rd && reg_addr == FPC_ADDR_STATUS
        |=> reg_rdata == {29'h0, $past(status_ff)})
        else $error("status read wrong");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside read cycle");

    AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !ce |=> $stable(status_ff) && $stable(mask_ff) && $stable(leds_ff)
            && $stable(onboard_rst_ff) && $stable(sysreset_oe_ff))
        else $error("state moved while clock enable low");

    // Reset outputs
    AST_ONBOARD_RST: assert property (@(posedge clk) disable iff (!rst_n)
        ce && reset_level |=> onboard_rst)
        else $error("onboard reset missing");

    AST_ONB_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && ce && !reset_level && !powerup_rst |=> !onboard_rst)
        else $error("onboard reset stuck");

    AST_SYSRST_ROLE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !sys_ctrl_role |=> !sysreset_oe)
        else $error("reset driven when not controller");

    AST_SYSRST_BTN: assert property (@(posedge clk) disable iff (!rst_n)
        ce && sys_ctrl_role && reset_level |=> sysreset_oe)
        else $error("button reset not sent to backplane");

    AST_SYSRST_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        !sysreset_out)
        else $error("backplane reset pin driven high");

    AST_SYSRST_SRC: assert property (@(posedge clk) disable iff (!rst_n)
        ce && sys_ctrl_role && (powerup_rst || wdog_expired || sw_sysrst_ff)
        |=> sysreset_oe)
        else $error("system reset source ignored");

    AST_SYSRST_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && ce && !(reset_level || powerup_rst || wdog_expired || sw_sysrst_ff)
        |=> !sysreset_oe)
        else $error("backplane reset without a source");

    // Indicators follow their condition one cycle later
    AST_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
        ce && board_fault |=> fail_led)
        else $error("fail led dark");

    AST_FAIL_DARK: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !board_fault |=> !fail_led)
        else $error("fail led lit without fault");

    AST_STAT: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> stat_led == $past(cpu_halted))
        else $error("status led wrong");

    AST_RUN: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> run_led == $past(lbus_cycle_active))
        else $error("run led wrong");

    AST_SYS_CTRL_LED: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> sys_controller_led == $past(sys_ctrl_role))
        else $error("controller led wrong");

    AST_NET: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> network_activity_led == $past(net_owns_lbus))
        else $error("net led wrong");

    AST_DISK: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> disk_activity_led == $past(disk_owns_lbus))
        else $error("disk led wrong");

    AST_BP: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (bp_master_xfer || bp_slave_access) |=> bp_activity_led)
        else $error("backplane led dark");

    AST_BP_DARK: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !bp_master_xfer && !bp_slave_access |=> !bp_activity_led)
        else $error("backplane led lit while idle");
endmodule

/* verilog/fpc_pkg.sv */
// Package of constants for the front panel control and indicator block
// Functional notes
// - One debounced abort press raises one edge-triggered interrupt event to the processor.
// - Reset pushbutton press resets every onboard device.
// - Pushbutton drives backplane system reset only when board is system controller.
// - Backplane reset request comes from button, power-up, watchdog or software bit.
// - Failure indicator lit whenever any board fault is detected.
// - Processor status indicator lit while processor is halted.
// - Run indicator lit while any local bus master runs a cycle.
// - System controller indicator lit while acting as backplane system controller.
// - Network activity indicator lit while network controller masters local bus.
// - Disk activity indicator lit while disk controller masters local bus.
// - Backplane activity indicator lit during backplane transfer or slave access.
package fpc_pkg;
    localparam logic [3:0]  FPC_ADDR_STATUS = 4'h0;
    localparam logic [3:0]  FPC_ADDR_MASK   = 4'h4;
    localparam logic [3:0]  FPC_ADDR_CTRL   = 4'h8;
    localparam logic [3:0]  FPC_ADDR_LEDS   = 4'hC;
    localparam int          FPC_ST_ABORT    = 0;
    localparam int          FPC_ST_RESET    = 1;
    localparam int          FPC_ST_WDOG     = 2;
    localparam int          FPC_CTRL_SYSRST = 0;
    localparam logic [2:0]  FPC_STATUS_RST  = 3'h0;
    localparam logic [2:0]  FPC_MASK_RST    = 3'h0;
    localparam int          FPC_DEB_NS      = 10000000;
    localparam int          FPC_CLK_MHZ     = 125;
    localparam int          FPC_DEB_CYC     = (FPC_DEB_NS / 1000) * FPC_CLK_MHZ;
    localparam int          FPC_RST_NS      = 200;
    localparam int          FPC_RST_CYC     = (FPC_RST_NS * FPC_CLK_MHZ + 999) / 1000;
endpackage

/* verilog/fpc_debounce.sv */
// Stability filter for one pushbutton input
`timescale 1ns/1ps
module fpc_debounce
    import fpc_pkg::*;
#(
    parameter int unsigned STABLE_CYC = FPC_DEB_CYC
)
(
    // Clock and control
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  ce,
    // Raw input and filtered result
    input  wire logic  raw_in,
    output logic       level_out,
    output logic       press_pulse
);
    logic        sync1_ff;
    logic        sync2_ff;
    logic        level_ff;
    logic [23:0] cnt_ff;
    logic        pulse_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end
        else if (ce)
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Accept only after STABLE_CYC equal samples; same length to rearm
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_ff   <= 24'h000000;
            level_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end
        else if (ce)
        begin
            pulse_ff <= 1'b0;
            if (sync2_ff == level_ff)
                cnt_ff <= 24'h000000;
            else if (cnt_ff >= 24'(STABLE_CYC - 1))
            begin
                cnt_ff   <= 24'h000000;
                level_ff <= sync2_ff;
                pulse_ff <= sync2_ff;
            end
            else
                cnt_ff <= cnt_ff + 24'h000001;
        end
    end

    assign level_out   = level_ff;
    assign press_pulse = pulse_ff;

    // A pulse held over by a low clock enable is still one event
    AST_ONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        pulse_ff && ce |=> !pulse_ff)
        else $error("press pulse longer than one cycle");

    AST_PULSE_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        pulse_ff && $past(ce) |-> level_ff && !$past(level_ff))
        else $error("pulse without rise");
endmodule

/* verification/fpc_btn_model.sv */
// Pushbutton model whose contact bounces after every change of the operator's hold
`timescale 1ns/1ps
module fpc_btn_model
(
    // Clock
    input  wire logic  clk,
    // Operator hold level and contact output
    input  wire logic  hold,
    output logic       btn
);
    logic        lvl_ff = 1'b0;
    logic [2:0]  bnc_ff = 3'h0;

    // Five chattering cycles per change, so no glitch is ever stable for long
    always_ff @(posedge clk)
    begin
        if (hold !== lvl_ff)
        begin
            lvl_ff <= hold;
            bnc_ff <= 3'h5;
        end
        else if (bnc_ff != 3'h0)
            bnc_ff <= bnc_ff - 3'h1;
    end

    assign btn = (bnc_ff != 3'h0) ? bnc_ff[0] : lvl_ff;
endmodule

/* verification/fpc_top_tb.sv */
// Self-checking testbench for the front panel block
`timescale 1ns/1ps
module fpc_top_tb;
    import fpc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ab_hold = 1'b0;
    logic        rb_hold = 1'b0;
    logic        pwr = 1'b0;
    logic        wdg = 1'b0;
    logic [7:0]  cond = 8'h00;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] reg_rdata;
    logic        abort_btn, reset_btn, onb, sro, soe, irq;
    logic [6:0]  leds;
    logic [31:0] d;
    int          n_fail = 0;
    int          n_compared = 0;

    always #4 clk = ~clk;

    fpc_btn_model u_abort_model (.clk(clk), .hold(ab_hold), .btn(abort_btn));
    fpc_btn_model u_reset_model (.clk(clk), .hold(rb_hold), .btn(reset_btn));

    fpc_top #(.DEB_CYC(4)) u_fpc_top (
        .clk(clk), .rst_n(rst_n), .ce(ce), .abort_btn(abort_btn), .reset_btn(reset_btn),
        .powerup_rst(pwr), .wdog_expired(wdg), .sys_ctrl_role(cond[3]),
        .board_fault(cond[0]), .cpu_halted(cond[1]), .lbus_cycle_active(cond[2]),
        .net_owns_lbus(cond[4]), .disk_owns_lbus(cond[5]), .bp_master_xfer(cond[6]),
        .bp_slave_access(cond[7]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .onboard_rst(onb),
        .sysreset_out(sro), .sysreset_oe(soe), .irq(irq), .fail_led(leds[0]),
        .stat_led(leds[1]), .run_led(leds[2]), .sys_controller_led(leds[3]),
        .network_activity_led(leds[4]), .disk_activity_led(leds[5]),
        .bp_activity_led(leds[6]));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    // Settle two nanoseconds past the edge so flop updates have landed
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) d = reg_rdata;
    endtask

    task automatic t_abort;
        @(posedge clk) ab_hold <= 1'b1;
        w(20);
        chk(irq, 0);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h1);
        wr(FPC_ADDR_MASK, 32'h7);
        w(1);
        chk(irq, 1);
        wr(FPC_ADDR_STATUS, 32'h1);
        w(8);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h0);
        @(posedge clk) ab_hold <= 1'b0;
        w(20);
        @(posedge clk) ab_hold <= 1'b1;
        w(2);
        @(posedge clk) ab_hold <= 1'b0;
        w(20);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h0);
        chk(irq, 0);
        @(posedge clk) ab_hold <= 1'b1;
        w(20);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h1);
        wr(FPC_ADDR_STATUS, 32'h7);
        // A release shorter than the filter must not rearm the button
        @(posedge clk) ab_hold <= 1'b0;
        w(2);
        @(posedge clk) ab_hold <= 1'b1;
        w(20);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h0);
        @(posedge clk) ab_hold <= 1'b0;
        wr(FPC_ADDR_STATUS, 32'h7);
    endtask

    task automatic t_reset_btn(input logic role);
        @(posedge clk) cond <= {4'h0, role, 3'h0};
        rb_hold <= 1'b1;
        w(20);
        chk({onb, soe, sro}, {1'b1, role, 1'b0});
        @(posedge clk) rb_hold <= 1'b0;
        w(20);
        chk({onb, soe}, 2'b00);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h2);
        wr(FPC_ADDR_STATUS, 32'h7);
    endtask

    task automatic t_sources;
        @(posedge clk) cond <= 8'h08;
        pwr <= 1'b1;
        w(3);
        chk({onb, soe}, 2'b11);
        @(posedge clk) pwr <= 1'b0;
        wdg <= 1'b1;
        w(3);
        chk({onb, soe}, 2'b01);
        @(posedge clk) wdg <= 1'b0;
        w(3);
        chk(soe, 0);
        rd(FPC_ADDR_STATUS);
        chk(d, 32'h4);
        wr(FPC_ADDR_CTRL, 32'h1);
        w(3);
        chk({soe, sro}, 2'b10);
        rd(FPC_ADDR_CTRL);
        chk(d, 32'h1);
        @(posedge clk) cond <= 8'h00;
        w(3);
        chk(soe, 0);
        wr(FPC_ADDR_CTRL, 32'h0);
        wr(FPC_ADDR_STATUS, 32'h7);
    endtask

    // Both backplane conditions light the same indicator
    task automatic t_leds;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk) cond <= 8'h01 << i;
            w(2);
            chk({25'h0, leds}, (i == 7) ? 32'h40 : (32'h1 << i));
        end
        @(posedge clk) cond <= 8'hFF;
        w(2);
        rd(FPC_ADDR_LEDS);
        chk(d, 32'h7F);
        @(posedge clk) cond <= 8'h00;
        rd(4'h2);
        chk(d, 32'h0);
    endtask

    // Clock enable low freezes all state, bus writes too; then a reset in mid-run
    task automatic t_ce;
        @(posedge clk) ce <= 1'b0;
        cond <= 8'h01;
        wr(FPC_ADDR_MASK, 32'h0);
        w(3);
        chk({25'h0, leds}, 32'h0);
        @(posedge clk) ce <= 1'b1;
        w(2);
        chk({25'h0, leds}, 32'h1);
        rd(FPC_ADDR_MASK);
        chk(d, 32'h7);
        @(posedge clk) cond <= 8'h00;
        w(2);
        @(posedge clk) rst_n <= 1'b0;
        w(5);
        chk({28'h0, onb, soe, sro, irq}, 32'h8);
        @(posedge clk) rst_n <= 1'b1;
        w(2);
        chk(onb, 0);
        rd(FPC_ADDR_MASK);
        chk(d, 32'h0);
    endtask

    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        w(4);
        chk({28'h0, onb, soe, sro, irq}, 32'h8);
        @(posedge clk) rst_n <= 1'b1;
        w(2);
        rd(FPC_ADDR_MASK);
        chk(d, 32'h0);
        chk(irq, 0);
        t_abort();
        t_reset_btn(1'b0);
        t_reset_btn(1'b1);
        t_sources();
        t_leds();
        t_ce();
        finish_test();
    end

    // Whole run takes a few hundred cycles; this bound is far beyond it
    initial
    begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule
